// >>> core/primary_serial_port.sv
`timescale 1ns/1ps
module primary_serial_port
  import serial_port_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        buffered_mode,
  input  wire logic        autobaud_req,
  input  wire logic [17:0] bit_cyc_set,
  input  wire logic        bit_cyc_load,
  output logic [17:0]      bit_cyc,
  output logic             autobaud_busy,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  input  wire logic        rx_take,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             rx_overrun,
  input  wire logic        download_active,
  input  wire logic        firmware_active,
  output logic             loader_valid,
  output logic [7:0]       loader_data,
  output logic             loader_firmware,
  output logic             app_owns_port
);

  // ************************************************************
  // Ownership of the port
  // ************************************************************
  owner_t owner, next_owner;
  always_comb begin
    next_owner = owner;
    // Firmware load wins over a code download; ownership follows the inputs one cycle later
    if (firmware_active)      next_owner = OWNER_FIRMWARE;
    else if (download_active) next_owner = OWNER_DOWNLOAD;
    else                      next_owner = OWNER_APP;
  end

  // ************************************************************
  // Bit timing and auto baud
  // ************************************************************
  ab_state_t        ab, next_ab;
  logic [DIV_W-1:0] ab_cnt, next_ab_cnt, next_bit_cyc;
  logic             rx_prev;

  always_comb begin
    next_ab      = ab;
    next_ab_cnt  = ab_cnt;
    next_bit_cyc = bit_cyc;
    if (bit_cyc_load && bit_cyc_set >= DIV_LO && bit_cyc_set <= DIV_HI)
      next_bit_cyc = bit_cyc_set;
    case (ab)
      AB_OFF:  if (autobaud_req) next_ab = AB_WAIT;
      AB_WAIT: begin
        if (rx_prev && !rxd) begin
          next_ab     = AB_MEAS;
          next_ab_cnt = 18'h1;
        end
      end
      AB_MEAS: begin
        // Length of the low start bit is taken as one bit period
        if (rxd) begin
          next_ab = AB_OFF;
          if (ab_cnt >= DIV_LO && ab_cnt <= DIV_HI) next_bit_cyc = ab_cnt;
        end else if (ab_cnt == DIV_HI) begin
          next_ab = AB_WAIT;        // Too slow: break or noise, try again
        end else begin
          next_ab_cnt = ab_cnt + 18'h1;
        end
      end
      default: next_ab = AB_OFF;
    endcase
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  rx_state_t        rx, next_rx;
  logic [DIV_W-1:0] rx_cnt, next_rx_cnt;
  logic [2:0]       rx_idx, next_rx_idx;
  logic [7:0]       rx_sh, next_rx_sh;
  logic             got_byte;

  always_comb begin
    next_rx     = rx;
    next_rx_cnt = rx_cnt;
    next_rx_idx = rx_idx;
    next_rx_sh  = rx_sh;
    got_byte    = 1'b0;
    case (rx)
      RX_IDLE: begin
        // Receiver is held off while the rate is being measured
        if (rx_prev && !rxd && ab == AB_OFF) begin
          next_rx     = RX_START;
          next_rx_cnt = {1'b0, bit_cyc[17:1]};
        end
      end
      RX_START: begin
        if (rx_cnt > 18'h1) next_rx_cnt = rx_cnt - 18'h1;
        else if (rxd) next_rx = RX_IDLE;        // Glitch, not a start bit
        else begin
          next_rx     = RX_DATA;
          next_rx_cnt = bit_cyc;
          next_rx_idx = 3'h0;
        end
      end
      RX_DATA: begin
        if (rx_cnt > 18'h1) next_rx_cnt = rx_cnt - 18'h1;
        else begin
          next_rx_sh  = {rxd, rx_sh[7:1]};
          next_rx_cnt = bit_cyc;
          next_rx_idx = rx_idx + 3'h1;
          if (rx_idx == 3'(DATA_BITS - 1)) next_rx = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_cnt > 18'h1) next_rx_cnt = rx_cnt - 18'h1;
        else begin
          next_rx  = RX_IDLE;
          // Bad stop bit drops the frame; no parity to
          got_byte = rxd;
        end
      end
      default: next_rx = RX_IDLE;
    endcase
  end

  // ************************************************************
  // Receive holding and background buffer
  // ************************************************************
  logic [7:0]        buf_mem [BUF_DEPTH];
  logic [BUF_AW:0]   wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic              hold_valid, next_hold_valid, next_overrun;
  logic [7:0]        hold_data, next_hold_data;
  logic              app_byte, buf_full, buf_empty;

  assign app_byte  = got_byte && owner == OWNER_APP;
  assign buf_full  = (wr_ptr[BUF_AW] != rd_ptr[BUF_AW]) &&
                     (wr_ptr[BUF_AW-1:0] == rd_ptr[BUF_AW-1:0]);
  assign buf_empty = (wr_ptr == rd_ptr);

  always_comb begin
    next_wr_ptr     = wr_ptr;
    next_rd_ptr     = rd_ptr;
    next_hold_valid = hold_valid;
    next_hold_data  = hold_data;
    next_overrun    = rx_overrun;
    if (buffered_mode) begin
      if (rx_take && !buf_empty) next_rd_ptr = rd_ptr + 5'h1;
      if (rx_take) next_overrun = 1'b0;
      // A lost byte beats a clear of the overrun flag in the same cycle
      if (app_byte) begin
        if (!buf_full || (rx_take && !buf_empty)) next_wr_ptr = wr_ptr + 5'h1;
        else next_overrun = 1'b1;
      end
      next_hold_valid = 1'b0;
    end else begin
      if (rx_take) begin
        next_hold_valid = 1'b0;
        next_overrun    = 1'b0;
      end
      if (app_byte) begin
        if (hold_valid && !rx_take) next_overrun = 1'b1;
        next_hold_valid = 1'b1;
        next_hold_data  = rx_sh;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (buffered_mode && app_byte && (!buf_full || (rx_take && !buf_empty)))
      buf_mem[wr_ptr[BUF_AW-1:0]] <= rx_sh;
  end

  assign rx_valid = buffered_mode ? !buf_empty : hold_valid;
  assign rx_data  = buffered_mode ? buf_mem[rd_ptr[BUF_AW-1:0]] : hold_data;

  // ************************************************************
  // Loader path and transmitter
  // ************************************************************
  logic tx_busy, tx_start;
  logic next_loader_valid;
  logic [7:0] next_loader_data;

  always_comb begin
    next_loader_valid = got_byte && owner != OWNER_APP;
    next_loader_data  = got_byte ? rx_sh : loader_data;
  end

  // Loader replies share the transmitter, so it is not gated by the owner
  assign tx_ready      = !tx_busy;
  assign tx_start      = tx_valid && !tx_busy;
  assign app_owns_port = (owner == OWNER_APP);
  assign loader_firmware = (owner == OWNER_FIRMWARE);
  assign autobaud_busy = (ab != AB_OFF);

  serial_tx u_tx (
    .clock   (clock),
    .nrst    (nrst),
    .bit_cyc (bit_cyc),
    .start   (tx_start),
    .data    (tx_data),
    .busy    (tx_busy),
    .txd     (txd)
  );

  // ************************************************************
  // State registers; nrst is an input only, never driven
  // ************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      owner       <= OWNER_APP;
      ab          <= AB_OFF;
      ab_cnt      <= '0;
      bit_cyc     <= DIV_RESET;
      rx_prev     <= 1'b1;
      rx          <= RX_IDLE;
      rx_cnt      <= '0;
      rx_idx      <= 3'h0;
      rx_sh       <= 8'h00;
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      hold_valid  <= 1'b0;
      hold_data   <= 8'h00;
      rx_overrun  <= 1'b0;
      loader_valid <= 1'b0;
      loader_data <= 8'h00;
    end else begin
      owner       <= next_owner;
      ab          <= next_ab;
      ab_cnt      <= next_ab_cnt;
      bit_cyc     <= next_bit_cyc;
      rx_prev     <= rxd;
      rx          <= next_rx;
      rx_cnt      <= next_rx_cnt;
      rx_idx      <= next_rx_idx;
      rx_sh       <= next_rx_sh;
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      hold_valid  <= next_hold_valid;
      hold_data   <= next_hold_data;
      rx_overrun  <= next_overrun;
      loader_valid <= next_loader_valid;
      loader_data <= next_loader_data;
    end
  end

endmodule // primary_serial_port

// >>> core/serial_port_pkg.sv
package serial_port_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int          CLOCK_HZ        = 50000000;
  localparam int          RESET_PULSE_NS  = 2000;
  localparam int          CLOCK_NS        = 20;
  localparam int          RESET_PULSE_CYC = (RESET_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int          BAUD_MIN        = 300;
  localparam int          BAUD_MAX        = 256000;
  // Bit period in clock cycles, longest at the slowest rate, shortest at the fastest
  localparam int          BIT_CYC_MAX     = CLOCK_HZ / BAUD_MIN;
  localparam int          BIT_CYC_MIN     = CLOCK_HZ / BAUD_MAX;
  localparam int          DIV_W           = 18;
  localparam logic [17:0] DIV_RESET       = 18'(CLOCK_HZ / 9600);
  localparam logic [17:0] DIV_LO          = 18'(BIT_CYC_MIN);
  localparam logic [17:0] DIV_HI          = 18'(BIT_CYC_MAX);

  // ************************************************************
  // Frame format and receive buffer
  // ************************************************************
  localparam int          DATA_BITS       = 8;
  localparam logic [3:0]  FRAME_BITS      = 4'h9;
  localparam int          BUF_DEPTH       = 16;
  localparam int          BUF_AW          = 4;

  // ************************************************************
  // Port ownership, receiver and auto baud states
  // ************************************************************
  typedef enum logic [1:0] {
    OWNER_APP      = 2'b00,
    OWNER_DOWNLOAD = 2'b01,
    OWNER_FIRMWARE = 2'b10
  } owner_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    AB_OFF   = 2'b00,
    AB_WAIT  = 2'b01,
    AB_MEAS  = 2'b10
  } ab_state_t;

endpackage

// >>> core/serial_tx.sv
`timescale 1ns/1ps
module serial_tx
  import serial_port_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [DIV_W-1:0] bit_cyc,
  input  wire logic             start,
  input  wire logic [7:0]       data,
  output logic                  busy,
  output logic                  txd
);

  logic [DIV_W-1:0] cnt, next_cnt;
  logic [3:0]       nbits, next_nbits;
  logic [8:0]       shreg, next_shreg;
  logic             next_txd;

  always_comb begin
    next_cnt   = cnt;
    next_nbits = nbits;
    next_shreg = shreg;
    next_txd   = txd;
    if (nbits == 4'h0) begin
      next_txd = 1'b1;
      if (start) begin
        // Start bit low, then data lsb first, then stop high
        next_shreg = {1'b1, data};
        next_txd   = 1'b0;
        next_nbits = FRAME_BITS + 4'h1;
        next_cnt   = bit_cyc;
      end
    end else if (cnt > 18'h1) begin
      next_cnt = cnt - 18'h1;
    end else begin
      next_cnt   = bit_cyc;
      next_nbits = nbits - 4'h1;
      next_txd   = (nbits == 4'h1) ? 1'b1 : shreg[0];
      next_shreg = {1'b1, shreg[8:1]};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt   <= '0;
      nbits <= 4'h0;
      shreg <= 9'h1ff;
      txd   <= 1'b1;
    end else begin
      cnt   <= next_cnt;
      nbits <= next_nbits;
      shreg <= next_shreg;
      txd   <= next_txd;
    end
  end

  assign busy = (nbits != 4'h0);

endmodule // serial_tx

// >>> test/serial_port_checker.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module serial_port_checker
  import serial_port_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        txd,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [17:0] bit_cyc_set,
  input wire logic        bit_cyc_load,
  input wire logic [17:0] bit_cyc,
  input wire logic        autobaud_req,
  input wire logic        autobaud_busy,
  input wire logic        download_active,
  input wire logic        firmware_active,
  input wire logic        loader_valid,
  input wire logic        loader_firmware,
  input wire logic        app_owns_port,
  input wire logic        rx_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_idle; tx_ready |-> txd; endproperty
  a_idle: assert property (p_idle) else $error("txd low while idle");
  property p_start; tx_valid && tx_ready |=> !txd && !tx_ready; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  // Shortest legal bit is far above eight cycles
  property p_bit; $fell(txd) |-> !txd [*8]; endproperty
  a_bit: assert property (p_bit) else $error("low bit too short");
  property p_rst; $rose(nrst) |-> bit_cyc == DIV_RESET && tx_ready && txd; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_load;
    bit_cyc_load && !autobaud_busy && bit_cyc_set >= DIV_LO && bit_cyc_set <= DIV_HI
      |=> bit_cyc == $past(bit_cyc_set);
  endproperty
  a_load: assert property (p_load) else $error("rate not loaded");
  property p_range;
    bit_cyc_load && !autobaud_busy && (bit_cyc_set < DIV_LO || bit_cyc_set > DIV_HI)
      |=> $stable(bit_cyc);
  endproperty
  a_range: assert property (p_range) else $error("bad rate taken");
  property p_dl; download_active || firmware_active |=> !app_owns_port; endproperty
  a_dl: assert property (p_dl) else $error("app owns during load");
  property p_app; !download_active && !firmware_active |=> app_owns_port; endproperty
  a_app: assert property (p_app) else $error("port not released");
  property p_fw; firmware_active |-> ##[0:1] loader_firmware; endproperty
  a_fw: assert property (p_fw) else $error("firmware owner missing");
  property p_ab; autobaud_req |=> autobaud_busy; endproperty
  a_ab: assert property (p_ab) else $error("auto baud not armed");

  c_tx: cover property (tx_valid && tx_ready);
  c_rx: cover property ($rose(rx_valid));
  c_ld: cover property (loader_valid);
endmodule // serial_port_checker

// >>> test/serial_peer.sv
`timescale 1ns/1ps
// ****
// Far end of the serial link
// ****
module serial_peer (
  input  wire logic        clock,
  output logic             rxd,
  input  wire logic        txd,
  input  wire logic [17:0] period
);
  logic [7:0] v;
  logic [8:0] got[$];

  initial rxd = 1'b1;

  // Rate is chosen by the bench inside the legal span
  task automatic send(input logic [7:0] b, input int cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clock);
      rxd = f[i];
      repeat (cyc - 1) @(negedge clock);
    end
  endtask

  // Stop bit is kept beside the byte so the bench can check framing
  always begin
    @(negedge txd);
    repeat (period / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (period) @(posedge clock);
      v[i] = txd;
    end
    repeat (period) @(posedge clock);
    got.push_back({txd, v});
  end
endmodule // serial_peer

// >>> test/test_primary_serial_port.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module test_primary_serial_port;
  import serial_port_pkg::*;
  logic        clock = 1'b0;
  logic        nrst, rxd, txd, buffered_mode, autobaud_req, bit_cyc_load, autobaud_busy;
  logic        tx_valid, tx_ready, rx_take, rx_valid, rx_overrun, download_active;
  logic        firmware_active, loader_valid, loader_firmware, app_owns_port;
  logic [17:0] bit_cyc_set, bit_cyc, per;
  logic [7:0]  tx_data, rx_data, loader_data, b, q[$];
  logic [15:0] lf;
  int          fail_count = 0;
  int          checked = 0;
  int          n;

  always #10 clock = ~clock;

  primary_serial_port uut (.clock, .nrst, .rxd, .txd, .buffered_mode, .autobaud_req,
    .bit_cyc_set, .bit_cyc_load, .bit_cyc, .autobaud_busy, .tx_valid, .tx_data, .tx_ready,
    .rx_take, .rx_valid, .rx_data, .rx_overrun, .download_active, .firmware_active,
    .loader_valid, .loader_data, .loader_firmware, .app_owns_port);
  serial_peer peer (.clock, .rxd, .txd, .period(per));

  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction

  task automatic cmp(input logic [17:0] g, input logic [17:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic load(input logic [17:0] v);
    bit_cyc_set = v;
    bit_cyc_load = 1'b1;
    @(negedge clock);
    bit_cyc_load = 1'b0;
    @(negedge clock);
  endtask

  task automatic send_tx(input logic [7:0] v);
    @(negedge clock);
    tx_data = v;
    tx_valid = 1'b1;
    for (int i = 0; i < 9000 && tx_ready !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    tx_valid = 1'b0;
  endtask

  task automatic pop(input logic [7:0] e);
    // Let one edge pass so two pops never raise rx_take in the step that lowered it
    @(negedge clock);
    for (int i = 0; i < 5000 && rx_valid !== 1'b1; i++) @(negedge clock);
    cmp(18'(rx_valid), 18'h1);
    cmp(18'(rx_data), 18'(e));
    rx_take = 1'b1;
    @(negedge clock);
    rx_take = 1'b0;
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {tx_valid, rx_take, buffered_mode, autobaud_req, bit_cyc_load} = '0;
    {download_active, firmware_active, nrst} = '0;
    tx_data = 8'h00;
    bit_cyc_set = 18'h0;
    per = DIV_RESET;
    lf = 16'h5b0c;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    cmp(bit_cyc, DIV_RESET);
    load(18'd100);
    cmp(bit_cyc, DIV_RESET);
    load(DIV_LO);
    cmp(bit_cyc, DIV_LO);
    per = DIV_LO;
    b = rnd();
    fork
      repeat (4) begin q.push_back(rnd()); send_tx(q[$]); end
      peer.send(b, per);
    join
    pop(b);
    for (n = 0; n < 3000 && peer.got.size() < 4; n++) @(negedge clock);
    foreach (q[i]) cmp(18'(peer.got[i]), 18'({1'b1, q[i]}));
    b = rnd();
    peer.send(rnd(), per);
    peer.send(b, per);
    cmp(18'(rx_overrun), 18'h1);
    pop(b);
    cmp(18'(rx_overrun), 18'h0);
    buffered_mode = 1'b1;
    q.delete();
    repeat (3) begin q.push_back(rnd()); peer.send(q[$], per); end
    foreach (q[i]) pop(q[i]);
    cmp(18'(rx_valid), 18'h0);
    buffered_mode = 1'b0;
    for (int m = 0; m < 2; m++) begin
      {firmware_active, download_active} = m ? 2'b10 : 2'b01;
      b = rnd();
      fork
        peer.send(b, per);
        begin
          for (n = 0; n < 3000 && loader_valid !== 1'b1; n++) @(negedge clock);
          cmp(18'(loader_data), 18'(b));
          cmp(18'(loader_firmware), 18'(m));
        end
      join
      cmp(18'(rx_valid), 18'h0);
    end
    {firmware_active, download_active} = 2'b00;
    repeat (2) @(negedge clock);
    cmp(18'(app_owns_port), 18'h1);
    b = rnd();
    peer.send(b, per);
    pop(b);
    autobaud_req = 1'b1;
    @(negedge clock);
    autobaud_req = 1'b0;
    peer.send(8'hff, 300);
    cmp(18'(bit_cyc >= 18'd298 && bit_cyc <= 18'd302), 18'h1);
    cmp(18'(autobaud_busy), 18'h0);
    cmp(18'(rx_valid), 18'h0);
    per = 18'd300;
    b = rnd();
    fork
      peer.send(b, per);
      send_tx(b);
    join
    pop(b);
    for (n = 0; n < 4000 && peer.got.size() < 5; n++) @(negedge clock);
    cmp(18'(peer.got[4]), 18'({1'b1, b}));
    wrap_up;
  end

  // Whole run is near 30000 cycles; this leaves ample margin
  initial begin
    repeat (90000) @(posedge clock);
    fail_count++;
    wrap_up;
  end
endmodule // test_primary_serial_port

bind primary_serial_port serial_port_checker chk (.clock, .nrst, .txd, .tx_valid, .tx_ready,
  .bit_cyc_set, .bit_cyc_load, .bit_cyc, .autobaud_req, .autobaud_busy, .download_active,
  .firmware_active, .loader_valid, .loader_firmware, .app_owns_port, .rx_valid);
